// ==== include/scs_regs.svh ====
// Purpose: register map, bit positions and timing figures
// Assumes: 10 MHz block clock, 32-bit classic Wishbone
// Notes: word index decoded from adr_i[3:2]
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH
`define SCS_ADR_CTRL 2'h0
`define SCS_ADR_STAT 2'h1
`define SCS_CTRL_RST 8'h00
`define SCS_C_START 0
`define SCS_C_WARM 1
`define SCS_C_V3 2
`define SCS_C_CSTOP 3
`define SCS_C_CLVL 4
`define SCS_C_DIV 6:5
`define SCS_C_IOEN 7
`define SCS_F_PCHG 0
`define SCS_F_SUPL 1
`define SCS_F_PROT 2
`define SCS_F_MUTE 3
`define SCS_F_EARLY 4
`define SCS_NIN 13
`define SCS_I_CCLK 0
`define SCS_I_CARD_PRESENCE 1
`define SCS_I_LPR 2
`define SCS_I_OC 3
`define SCS_I_OT 4
`define SCS_I_VDDF 5
`define SCS_I_VCCF 6
`define SCS_I_CARD 9:7
`define SCS_I_CARD0 7
`define SCS_I_HOST 12:10
`define SCS_I_HOST0 10
`define SCS_CLK_MHZ 10
`define SCS_T_IV_US 100
`define SCS_T_REC_MS 10
`define SCS_WARM_CC 42000
`define SCS_MUTE_CC 40000
`define SCS_EARLY_CC 400
`endif

// ==== include/scs_pkg.sv ====
// Purpose: types of the card session sequencer
// Assumes: constants come from scs_regs.svh
// Notes: state encodings are one-hot
`default_nettype none
`include "scs_regs.svh"
package scs_pkg;
   typedef enum logic [10:0] {
      ST_IDLE = 11'h001,
      ST_PD = 11'h002,
      ST_REC = 11'h004,
      ST_A1 = 11'h008,
      ST_A2 = 11'h010,
      ST_A3 = 11'h020,
      ST_SES = 11'h040,
      ST_D1 = 11'h080,
      ST_D2 = 11'h100,
      ST_D3 = 11'h200,
      ST_D4 = 11'h400
   } scs_seq_t;
   typedef enum logic [2:0] {
      LN_NEU = 3'h1,
      LN_H2C = 3'h2,
      LN_C2H = 3'h4
   } scs_lane_t;
   typedef struct packed {
      scs_seq_t st;
      scs_lane_t [2:0] lane;
      logic [`SCS_NIN-1:0] sy1;
      logic [`SCS_NIN-1:0] sy2;
      logic [`SCS_NIN-1:0] sy3;
      logic [`SCS_NIN-1:0] filt;
      logic [`SCS_NIN-1:0] pfilt;
      logic [7:0] ctrl;
      logic start_q;
      logic warm_q;
      logic [4:0] flg;
      logic [19:0] tmr;
      logic [19:0] vcnt;
      logic vhold;
      logic [15:0] ccnt;
      logic atr;
      logic warm;
      logic rst;
      logic clk_on;
      logic io_rx;
      logic vcc_on;
      logic intn;
      logic ack;
      logic [7:0] dat;
      logic [2:0] coe;
      logic [2:0] hoe;
   } scs_state_t;
endpackage : scs_pkg
`default_nettype wire

// ==== hw/scs_seq.sv ====
// Purpose: smart card session sequencer with Wishbone registers
// Assumes: all pins asynchronous to clk_i, card clock sampled
// Notes: lines are open drain, oe high pulls the line low
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`default_nettype none
`include "scs_regs.svh"
module scs_seq
   import scs_pkg::*;
#(
   parameter int T_IV_US = `SCS_T_IV_US,
   parameter int REC_CYC = `SCS_T_REC_MS * 1000 * `SCS_CLK_MHZ,
   parameter int WARM_CC = `SCS_WARM_CC,
   parameter int MUTE_CC = `SCS_MUTE_CC,
   parameter int EARLY_CC = `SCS_EARLY_CC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic card_clk_i,
   input wire logic card_presence_i,
   input wire logic low_power_request_i,
   input wire logic over_current_i,
   input wire logic over_temp_i,
   input wire logic vdd_fault_i,
   input wire logic vcc_fault_i,
   // bit 0 data line, bit 1 aux line a, bit 2 aux line b
   input wire logic [2:0] card_lines_i,
   output logic [2:0] card_lines_o,
   output logic [2:0] card_lines_oe_o,
   input wire logic [2:0] host_lines_i,
   output logic [2:0] host_lines_o,
   output logic [2:0] host_lines_oe_o,
   output logic card_vcc_en_o,
   output logic card_vsel_3v_o,
   output logic card_rst_o,
   output logic card_clk_en_o,
   output logic card_clk_stop_high_o,
   output logic [1:0] card_clk_div_o,
   output logic low_power_state_o,
   output logic int_n_o
);
   localparam int IV_CYC = T_IV_US * `SCS_CLK_MHZ;
   localparam logic [19:0] IV_M1 = 20'(IV_CYC - 1);
   localparam logic [19:0] REC_M1 = 20'(REC_CYC - 1);
   localparam logic [15:0] WARM_M1 = 16'(WARM_CC - 1);
   localparam logic [15:0] MUTE_M1 = 16'(MUTE_CC - 1);
   localparam logic [15:0] EARLY_V = 16'(EARLY_CC);

   function automatic logic adr_is(input logic [3:0] a, input logic [1:0] idx);
      adr_is = (a[3:2] == idx);
   endfunction : adr_is

   scs_state_t q;
   scs_state_t n;
   logic req;
   logic rd_stat;
   logic wr_ctrl;
   logic [`SCS_NIN-1:0] rise;
   logic [`SCS_NIN-1:0] fall;
   logic [4:0] fset;
   logic [4:0] fclr;
   logic fault;
   logic tend;
   logic lane_en;
   logic [7:0] stat;

   ////////////////////////////////////////////////////////////////
   always_comb begin
      n = q;
      req = wb_cyc_i & wb_stb_i;
      rd_stat = req & ~q.ack & ~wb_we_i & adr_is(wb_adr_i, `SCS_ADR_STAT);
      wr_ctrl = req & q.ack & wb_we_i & wb_sel_i[0] & adr_is(wb_adr_i, `SCS_ADR_CTRL);
      rise = q.filt & ~q.pfilt;
      fall = ~q.filt & q.pfilt;
      fset = 5'h00;
      fclr = 5'h00;
      tend = (q.tmr == IV_M1);
      // input synchronisers, accept once stages 2 and 3 agree
      n.sy1 = {host_lines_i, card_lines_i, vcc_fault_i, vdd_fault_i,
               over_temp_i, over_current_i, low_power_request_i,
               card_presence_i, card_clk_i};
      n.sy2 = q.sy1;
      n.sy3 = q.sy2;
      for (int i = 0; i < `SCS_NIN; i++) begin
         if (q.sy2[i] == q.sy3[i]) begin
            n.filt[i] = q.sy3[i];
         end
      end
      n.pfilt = q.filt;
      stat = {q.vcc_on, q.flg[`SCS_F_EARLY], q.flg[`SCS_F_MUTE],
              q.flg[`SCS_F_PROT], q.flg[`SCS_F_SUPL], q.filt[`SCS_I_CARD0],
              q.flg[`SCS_F_PCHG], q.filt[`SCS_I_CARD_PRESENCE]};
      ////////////////////////////////////////////////////////////////
      // bus slave: ack one cycle after request, drop after one
      n.ack = req & ~q.ack;
      if (req & ~q.ack) begin
         n.dat = adr_is(wb_adr_i, `SCS_ADR_CTRL) ? q.ctrl :
                 adr_is(wb_adr_i, `SCS_ADR_STAT) ? stat : 8'h00;
      end
      if (rd_stat) begin
         fclr = 5'h1F;
      end
      ////////////////////////////////////////////////////////////////
      // supply supervisor hold
      if (q.filt[`SCS_I_VDDF]) begin
         n.vhold = 1'b1;
         n.vcnt = 20'h00000;
      end else if (q.vhold) begin
         n.vcnt = q.vcnt + 20'h00001;
         if (q.vcnt == IV_M1) begin
            n.vhold = 1'b0;
         end
      end
      if (rise[`SCS_I_CARD_PRESENCE] | fall[`SCS_I_CARD_PRESENCE]) begin
         fset[`SCS_F_PCHG] = 1'b1;
      end
      if (rise[`SCS_I_VDDF] | (q.vcc_on & rise[`SCS_I_VCCF])) begin
         fset[`SCS_F_SUPL] = 1'b1;
      end
      if (q.vcc_on & (q.filt[`SCS_I_OC] | q.filt[`SCS_I_OT])) begin
         fset[`SCS_F_PROT] = 1'b1;
      end
      fault = q.filt[`SCS_I_VDDF] | (q.vcc_on & (q.filt[`SCS_I_OC] | q.filt[`SCS_I_OT]
              | q.filt[`SCS_I_VCCF] | ~q.filt[`SCS_I_CARD_PRESENCE]));
      ////////////////////////////////////////////////////////////////
      // control register, warm bit cleared by hardware
      n.start_q = q.ctrl[`SCS_C_START];
      n.warm_q = q.ctrl[`SCS_C_WARM];
      n.tmr = q.tmr + 20'h00001;
      case (q.st)
         ST_IDLE: begin
            n.tmr = 20'h00000;
            if (q.filt[`SCS_I_LPR]) begin
               n.st = ST_PD;
            end else if (q.ctrl[`SCS_C_START] & ~q.start_q & ~q.vhold) begin
               n.st = ST_A1;
               n.vcc_on = 1'b1;
               fclr[`SCS_F_MUTE] = 1'b1;
               fclr[`SCS_F_EARLY] = 1'b1;
            end
         end
         ST_PD: begin
            n.tmr = 20'h00000;
            if (~q.filt[`SCS_I_LPR]) begin
               n.st = ST_REC;
            end
         end
         ST_REC: begin
            if (q.filt[`SCS_I_LPR]) begin
               n.st = ST_PD;
            end else if (q.tmr == REC_M1) begin
               n.st = ST_IDLE;
            end
         end
         ST_A1: begin
            if (tend) begin
               n.tmr = 20'h00000;
               if (q.filt[`SCS_I_VCCF]) begin
                  n.st = ST_D1;
                  fset[`SCS_F_SUPL] = 1'b1;
               end else begin
                  n.st = ST_A2;
                  n.io_rx = 1'b1;
               end
            end
         end
         ST_A2: begin
            if (tend) begin
               n.tmr = 20'h00000;
               n.st = ST_A3;
               n.clk_on = 1'b1;
            end
         end
         ST_A3: begin
            if (tend) begin
               n.st = ST_SES;
               n.rst = 1'b1;
               n.atr = 1'b1;
               n.ccnt = 16'h0000;
            end
         end
         ST_SES: begin
            if (q.ctrl[`SCS_C_WARM] & ~q.warm_q) begin
               n.warm = 1'b1;
               n.rst = 1'b0;
               n.atr = 1'b0;
               n.ccnt = 16'h0000;
            end else if (q.warm) begin
               if (rise[`SCS_I_CCLK]) begin
                  n.ccnt = q.ccnt + 16'h0001;
                  if (q.ccnt == WARM_M1) begin
                     n.warm = 1'b0;
                     n.rst = 1'b1;
                     n.atr = 1'b1;
                     n.ccnt = 16'h0000;
                  end
               end
            end else if (q.atr) begin
               if (fall[`SCS_I_CARD0]) begin
                  n.atr = 1'b0;
                  n.ctrl[`SCS_C_WARM] = 1'b0;
                  if (q.ccnt < EARLY_V) begin
                     fset[`SCS_F_EARLY] = 1'b1;
                  end
               end else if (rise[`SCS_I_CCLK]) begin
                  n.ccnt = q.ccnt + 16'h0001;
                  if (q.ccnt == MUTE_M1) begin
                     n.atr = 1'b0;
                     n.ctrl[`SCS_C_WARM] = 1'b0;
                     fset[`SCS_F_MUTE] = 1'b1;
                  end
               end
            end
         end
         ST_D1: begin
            if (tend) begin
               n.tmr = 20'h00000;
               n.st = ST_D2;
               n.rst = 1'b0;
            end
         end
         ST_D2: begin
            if (tend) begin
               n.tmr = 20'h00000;
               n.st = ST_D3;
               n.clk_on = 1'b0;
            end
         end
         ST_D3: begin
            if (tend) begin
               n.tmr = 20'h00000;
               n.st = ST_D4;
               n.io_rx = 1'b0;
            end
         end
         ST_D4: begin
            if (tend) begin
               n.st = ST_IDLE;
               n.vcc_on = 1'b0;
            end
         end
         default: begin
            n.st = ST_IDLE;
         end
      endcase
      if ((q.st == ST_A1 || q.st == ST_A2 || q.st == ST_A3 || q.st == ST_SES) &&
          (fault | ~q.ctrl[`SCS_C_START])) begin
         n.st = ST_D1;
         n.tmr = 20'h00000;
         n.atr = 1'b0;
         n.warm = 1'b0;
      end
      if (wr_ctrl) begin
         n.ctrl = wb_dat_i[7:0];
      end
      n.flg = (q.flg & ~fclr) | fset;
      ////////////////////////////////////////////////////////////////
      // data steering, first falling side becomes input
      lane_en = q.ctrl[`SCS_C_IOEN] & q.io_rx;
      for (int i = 0; i < 3; i++) begin
         case (q.lane[i])
            LN_NEU: begin
               if (lane_en & fall[`SCS_I_HOST0 + i]) begin
                  n.lane[i] = LN_H2C;
               end else if (lane_en & fall[`SCS_I_CARD0 + i]) begin
                  n.lane[i] = LN_C2H;
               end
            end
            LN_H2C: begin
               if (~lane_en | rise[`SCS_I_HOST0 + i]) begin
                  n.lane[i] = LN_NEU;
               end
            end
            LN_C2H: begin
               if (~lane_en | rise[`SCS_I_CARD0 + i]) begin
                  n.lane[i] = LN_NEU;
               end
            end
            default: begin
               n.lane[i] = LN_NEU;
            end
         endcase
         n.coe[i] = ~q.io_rx | ((q.lane[i] == LN_H2C) & ~q.filt[`SCS_I_HOST0 + i]);
         n.hoe[i] = (q.lane[i] == LN_C2H) & ~q.filt[`SCS_I_CARD0 + i];
      end
      ////////////////////////////////////////////////////////////////
      // interrupt pin
      if (q.st == ST_PD) begin
         n.intn = q.filt[`SCS_I_CARD_PRESENCE];
      end else if (q.st == ST_REC) begin
         n.intn = 1'b0;
      end else begin
         n.intn = ~(q.vhold | q.filt[`SCS_I_VDDF] | (|q.flg));
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.st <= ST_IDLE;
         q.lane <= '{LN_NEU, LN_NEU, LN_NEU};
         q.ctrl <= `SCS_CTRL_RST;
         q.vhold <= 1'b1;
         q.coe <= 3'h7;
      end else begin
         q <= n;
      end
   end

   assign wb_ack_o = q.ack;
   assign wb_dat_o = {24'h000000, q.dat};
   assign card_lines_o = 3'h0;
   assign card_lines_oe_o = q.coe;
   assign host_lines_o = 3'h0;
   assign host_lines_oe_o = q.hoe;
   assign card_vcc_en_o = q.vcc_on;
   assign card_vsel_3v_o = q.ctrl[`SCS_C_V3];
   assign card_rst_o = q.rst;
   assign card_clk_en_o = q.clk_on & ~q.ctrl[`SCS_C_CSTOP];
   assign card_clk_stop_high_o = q.ctrl[`SCS_C_CLVL];
   assign card_clk_div_o = q.ctrl[`SCS_C_DIV];
   assign low_power_state_o = (q.st == ST_PD);
   assign int_n_o = q.intn;

   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_d1_to_d2;
      (q.st == ST_D1) ##1 (q.st == ST_D2);
   endsequence
   sequence s_oc_in_session;
      (q.st == ST_SES) && q.filt[`SCS_I_OC] && q.ctrl[`SCS_C_START];
   endsequence

   property p_vsel;
      wr_ctrl |=> card_vsel_3v_o == $past(wb_dat_i[`SCS_C_V3]);
   endproperty
   a_vsel: assert property (p_vsel) else $error("supply select not applied");

   property p_oc;
      s_oc_in_session |=> (q.st == ST_D1) ##1 !int_n_o;
   endproperty
   a_oc: assert property (p_oc) else $error("over-current not handled");

   property p_pd;
      (q.st == ST_PD) |=> (q.st == ST_PD || q.st == ST_REC);
   endproperty
   a_pd: assert property (p_pd) else $error("left low power without recovery");

   property p_deact;
      s_d1_to_d2 |-> !card_rst_o && card_vcc_en_o;
   endproperty
   a_deact: assert property (p_deact) else $error("deactivation order wrong");

   property p_idle_lines;
      (q.st == ST_IDLE) |-> card_lines_oe_o == 3'h7 && card_lines_o == 3'h0;
   endproperty
   a_idle_lines: assert property (p_idle_lines) else $error("card lines not low");

   property p_rd_clear;
      (rd_stat && fset == 5'h00) |=> q.flg == 5'h00;
   endproperty
   a_rd_clear: assert property (p_rd_clear) else $error("flags not cleared");

   property p_vdd_hold;
      $fell(q.filt[`SCS_I_VDDF]) |-> !int_n_o [*8];
   endproperty
   a_vdd_hold: assert property (p_vdd_hold) else $error("interrupt released early");

   property p_warm;
      ((q.st == ST_SES) && q.ctrl[`SCS_C_WARM] && !q.warm_q && !fault && q.ctrl[`SCS_C_START])
         |=> !card_rst_o [*8];
   endproperty
   a_warm: assert property (p_warm) else $error("warm reset too short");
endmodule : scs_seq
`default_nettype wire

// ==== bench/scs_card_model.sv ====
// Purpose: card and card clock model for the session sequencer bench
// Assumes: card clock of 800 ns, card lines pulled up
// Notes: answer_cc_i of 0 gives a mute card
`default_nettype none
module scs_card_model (
   input wire logic clk_en_i,
   input wire logic rst_n_i,
   input wire logic [2:0] dev_oe_i,
   input wire integer answer_cc_i,
   output logic card_clk_o,
   output logic [2:0] lines_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt;
   logic drive_low;
   ////////////////////////////////////////////////////////////////////////////
   // clock stands still low outside a session
   initial begin
      card_clk_o = 1'b0;
      forever begin
         #400;
         card_clk_o = clk_en_i ? ~card_clk_o : 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // answer counted from reset release, data low for four clocks
   always @(posedge card_clk_o or negedge rst_n_i) begin
      if (!rst_n_i) cnt <= 0;
      else cnt <= cnt + 1;
   end
   assign drive_low = answer_cc_i > 0 && cnt >= answer_cc_i && cnt < answer_cc_i + 4;
   assign lines_o = ~(dev_oe_i | {2'b00, drive_low});
endmodule : scs_card_model
`default_nettype wire

// ==== bench/smart_card_session_sequencer_bench.sv ====
// Purpose: self-checking bench of the card session sequencer
// Assumes: shortened counts, interval of 20 clocks
// Notes: fixed seed, random config, answer delay and lane
`default_nettype none
module smart_card_session_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int IV = 20;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [3:0] wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic card_clk_i, card_presence, lpr, oc, ot, vddf, vccf;
   logic [2:0] card_lines_i, card_lines_o, card_lines_oe_o;
   logic [2:0] host_lines_i, host_lines_o, host_lines_oe_o, host_pull;
   logic card_vcc_en_o, card_vsel_3v_o, card_rst_o, card_clk_en_o;
   logic card_clk_stop_high_o, low_power_state_o, int_n_o;
   logic [1:0] card_clk_div_o;
   logic [7:0] fexp [4] = '{8'h11, 8'h11, 8'h02, 8'h09};
   int answer_cc, lane, miscompares, compares;
   assign host_lines_i = ~(host_lines_oe_o | host_pull);
   scs_seq #(.T_IV_US(2), .REC_CYC(200), .WARM_CC(50), .MUTE_CC(60), .EARLY_CC(5))
   scs_seq_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .card_clk_i(card_clk_i),
      .card_presence_i(card_presence), .low_power_request_i(lpr), .over_current_i(oc),
      .over_temp_i(ot), .vdd_fault_i(vddf), .vcc_fault_i(vccf), .card_lines_i(card_lines_i),
      .card_lines_o(card_lines_o), .card_lines_oe_o(card_lines_oe_o),
      .host_lines_i(host_lines_i), .host_lines_o(host_lines_o),
      .host_lines_oe_o(host_lines_oe_o), .card_vcc_en_o(card_vcc_en_o),
      .card_vsel_3v_o(card_vsel_3v_o), .card_rst_o(card_rst_o),
      .card_clk_en_o(card_clk_en_o), .card_clk_stop_high_o(card_clk_stop_high_o),
      .card_clk_div_o(card_clk_div_o), .low_power_state_o(low_power_state_o),
      .int_n_o(int_n_o));
   scs_card_model scs_card_model_inst (.clk_en_i(card_clk_en_o), .rst_n_i(card_rst_o),
      .dev_oe_i(card_lines_oe_o), .answer_cc_i(answer_cc), .card_clk_o(card_clk_i),
      .lines_o(card_lines_i));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %0t %s got %h want %h", $time, m, got, exp);
      end
   endtask : chk
   task tally_and_finish;
      if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   // classic single cycle, held until ack
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] q);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= {24'h000000, d};
      // ack ends this wait, the watchdog only if ack never comes
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
      chk(wb_ack_o, 1'b0, "ack held");
   endtask : wb
   task automatic wr(input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, 4'h0, d, q);
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] q);
      wb(1'b0, a, 8'h00, q);
   endtask : rd
   function automatic logic sig(input int w);
      case (w)
         0: return int_n_o;
         1: return card_vcc_en_o;
         2: return card_rst_o;
         3: return low_power_state_o;
         default: return card_lines_oe_o[lane];
      endcase
   endfunction : sig
   task automatic wait_sig(input int w, input logic v, input int lim, output int n);
      n = 0;
      while (sig(w) !== v && n < lim) begin
         @(negedge clk_i);
         n++;
      end
      chk(sig(w), v, "wait");
   endtask : wait_sig
   // step order: activation vcc rx clk rst, deactivation rst clk rx vcc
   function automatic logic [3:0] cond(input logic act);
      if (act) return {card_rst_o === 1'b1, card_clk_en_o === 1'b1,
                       card_lines_oe_o === 3'h0, card_vcc_en_o === 1'b1};
      return {card_vcc_en_o === 1'b0, card_lines_oe_o === 3'h7,
              card_clk_en_o === 1'b0, card_rst_o === 1'b0};
   endfunction : cond
   task automatic seq4(input logic act);
      int t[4];
      logic [3:0] c;
      t = '{-1, -1, -1, -1};
      for (int n = 0; n < 200 && t[3] < 0; n++) begin
         @(negedge clk_i);
         c = cond(act);
         for (int i = 0; i < 4; i++) if (t[i] < 0 && c[i]) t[i] = n;
      end
      for (int i = 1; i < 4; i++) chk((t[i] - t[i-1]) inside {[IV-1:IV+2]}, 1'b1, "step");
   endtask : seq4
   task automatic start_session(input logic [7:0] c);
      wr(c);
      wr(c | 8'h01);
      seq4(1'b1);
   endtask : start_session
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   initial begin
      repeat (40000) @(posedge clk_i);
      miscompares++;
      tally_and_finish();
   end
   initial begin
      logic [7:0] q, b;
      int n;
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      rst_i = 1'b1;
      {card_presence, lpr, oc, ot, vddf, vccf, host_pull} = '0;
      answer_cc = 10;
      lane = 0;
      miscompares = 0;
      compares = 0;
      void'($urandom(32'hA0F219DE));
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk(int_n_o, 1'b0, "int at reset");
      chk(card_lines_oe_o, 3'h7, "card lines");
      chk(host_lines_oe_o, 3'h0, "host lines");
      chk(host_lines_o, 3'h0, "host drive");
      wait_sig(0, 1'b1, 100, n);
      rd(4'h0, q);
      chk(q, 8'h00, "ctrl default");
      rd(4'h8, q);
      chk(q, 8'h00, "unmapped");
      @(posedge clk_i) card_presence <= 1'b1;
      wait_sig(0, 1'b0, 20, n);
      rd(4'h4, q);
      chk(q, 8'h03, "insert status");
      wait_sig(0, 1'b1, 5, n);
      rd(4'h4, q);
      chk(q, 8'h01, "flag cleared");
      for (int k = 0; k < 4; k++) begin
         b = 8'($urandom) & 8'h74;
         wr(b);
         repeat (2) @(negedge clk_i);
         chk(card_vsel_3v_o, b[2], "voltage");
         chk({card_clk_stop_high_o, card_clk_div_o}, {b[4], b[6:5]}, "clock cfg");
         rd(4'h0, q);
         chk(q, b, "ctrl readback");
      end
      wr(8'h00);
      // early answer
      answer_cc = 3;
      start_session(8'h00);
      wait_sig(0, 1'b0, 300, n);
      rd(4'h4, q);
      chk(q & 8'hFB, 8'hC1, "early");
      rd(4'h4, q);
      chk(q & 8'hFB, 8'h81, "early read");
      wr(8'h00);
      seq4(1'b0);
      // mute card, warm reset, lanes
      answer_cc = 0;
      start_session(8'h00);
      wait_sig(0, 1'b0, 700, n);
      rd(4'h4, q);
      chk(q, 8'hA5, "mute");
      wr(8'h03);
      wait_sig(2, 1'b0, 20, n);
      wait_sig(2, 1'b1, 700, n);
      chk(n inside {[390:412]}, 1'b1, "warm length");
      wait_sig(0, 1'b0, 700, n);
      rd(4'h0, q);
      chk(q, 8'h01, "warm self clear");
      rd(4'h4, q);
      wr(8'h09);
      repeat (2) @(negedge clk_i);
      chk(card_clk_en_o, 1'b0, "clock stop");
      wr(8'h01);
      repeat (2) @(negedge clk_i);
      chk(card_clk_en_o, 1'b1, "clock resumed");
      wr(8'h81);
      lane = $urandom % 3;
      @(posedge clk_i) host_pull[lane] <= 1'b1;
      wait_sig(4, 1'b1, 20, n);
      chk(host_lines_oe_o, 3'h0, "host side input");
      @(posedge clk_i) host_pull[lane] <= 1'b0;
      wait_sig(4, 1'b0, 20, n);
      wr(8'h80);
      seq4(1'b0);
      wr(8'h00);
      // faults in session
      for (int k = 0; k < 4; k++) begin
         answer_cc = 6 + $urandom % 40;
         start_session(8'h00);
         @(posedge clk_i);
         case (k)
            0: oc <= 1'b1;
            1: ot <= 1'b1;
            2: card_presence <= 1'b0;
            default: vccf <= 1'b1;
         endcase
         seq4(1'b0);
         wait_sig(0, 1'b0, 20, n);
         rd(4'h4, q);
         chk(q, fexp[k], "fault status");
         @(posedge clk_i) {oc, ot, card_presence, vccf} <= 4'b0010;
         repeat (10) @(posedge clk_i);
         rd(4'h4, q);
         wr(8'h00);
      end
      // system supply fault
      start_session(8'h04);
      @(posedge clk_i) vddf <= 1'b1;
      seq4(1'b0);
      rd(4'h4, q);
      chk(q, 8'h09, "supply status");
      rd(4'h0, q);
      chk(q, 8'h05, "ctrl kept");
      @(posedge clk_i) vddf <= 1'b0;
      repeat (10) @(negedge clk_i);
      chk(int_n_o, 1'b0, "supply hold");
      rd(4'h4, q);
      wait_sig(0, 1'b1, 60, n);
      wr(8'h00);
      // low power with start bit clear
      @(posedge clk_i) lpr <= 1'b1;
      wait_sig(3, 1'b1, 20, n);
      @(posedge clk_i) card_presence <= 1'b0;
      wait_sig(0, 1'b0, 20, n);
      @(posedge clk_i) card_presence <= 1'b1;
      wait_sig(0, 1'b1, 20, n);
      wr(8'h01);
      rd(4'h4, q);
      @(posedge clk_i) lpr <= 1'b0;
      wait_sig(3, 1'b0, 20, n);
      // interrupt follows the state one cycle later
      @(negedge clk_i);
      chk(int_n_o, 1'b0, "recovery int");
      wait_sig(0, 1'b1, 400, n);
      chk(n >= 170, 1'b1, "recovery time");
      chk(card_vcc_en_o, 1'b0, "start ignored");
      start_session(8'h00);
      wr(8'h00);
      seq4(1'b0);
      tally_and_finish();
   end
endmodule : smart_card_session_sequencer_bench
`default_nettype wire
